// >>> lcd_driver_top.sv
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module lcd_driver_top #(
  parameter int FCLK_DIV = lcd_pkg::FCLK_DIV_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic scl,
  input wire logic sda,
  output logic lcd_supply_level_q,
  output logic bias_half_q,
  output logic [1:0] drive_mode_q,
  output logic [1:0] row_sel_q,
  output logic [59:0] seg_q
);
  // ---------------- register bus ----------------
  logic aw_have_q, w_have_q, data_mode_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [5:0] raddr_q;
  logic [31:0] rd_mux;
  logic aw_hs, w_hs, ar_hs, do_wr, wr_hit;
  lcd_pkg::lcd_status_s st_q;
  logic [3:0] ram_q [lcd_pkg::RAM_DEPTH];
  logic frame, phase_q;

  assign aw_hs = awvalid & awready;
  assign w_hs = wvalid & wready;
  assign ar_hs = arvalid & arready;
  assign do_wr = aw_have_q & w_have_q & ~bvalid;
  assign wr_hit = awaddr_q == lcd_pkg::ADDR_CTRL || awaddr_q == lcd_pkg::ADDR_RADDR
    || awaddr_q == lcd_pkg::ADDR_STAT || awaddr_q == lcd_pkg::ADDR_RDATA;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      bvalid <= 1'b0;
      bresp <= lcd_pkg::RESP_OKAY;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (aw_hs) begin
        awaddr_q <= awaddr;
        awready <= 1'b0;
        aw_have_q <= 1'b1;
      end
      if (w_hs) begin
        wdata_q <= wdata;
        wstrb_q <= wstrb;
        wready <= 1'b0;
        w_have_q <= 1'b1;
      end
      if (do_wr) begin
        bvalid <= 1'b1;
        bresp <= wr_hit ? lcd_pkg::RESP_OKAY : lcd_pkg::RESP_DECERR;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // status and data registers are read only; writes there are ignored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_mode_q <= 1'b0;
      raddr_q <= 6'h00;
    end else if (do_wr && wstrb_q[0]) begin
      if (awaddr_q == lcd_pkg::ADDR_CTRL) begin
        data_mode_q <= wdata_q[0];
      end
      if (awaddr_q == lcd_pkg::ADDR_RADDR) begin
        raddr_q <= wdata_q[5:0];
      end
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (araddr)
      lcd_pkg::ADDR_CTRL: rd_mux[0] = data_mode_q;
      lcd_pkg::ADDR_STAT: begin
        rd_mux[lcd_pkg::STAT_FRAME-1:0] = st_q;
        rd_mux[lcd_pkg::STAT_FRAME] = frame;
        rd_mux[lcd_pkg::STAT_PHASE] = phase_q;
      end
      lcd_pkg::ADDR_RADDR: rd_mux[5:0] = raddr_q;
      lcd_pkg::ADDR_RDATA: rd_mux[3:0] = (raddr_q < 6'd60) ? ram_q[raddr_q] : 4'h0;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= lcd_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_mux;
      rresp <= (araddr == lcd_pkg::ADDR_CTRL || araddr == lcd_pkg::ADDR_STAT ||
        araddr == lcd_pkg::ADDR_RADDR || araddr == lcd_pkg::ADDR_RDATA) ?
        lcd_pkg::RESP_OKAY : lcd_pkg::RESP_DECERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ---------------- serial link and decoding ----------------
  logic byte_valid;
  logic [7:0] byte_data;
  lcd_pkg::lcd_cmd_s cmd;
  logic cmd_go, data_go, bank_ok;

  lcd_i2c_rx u_rx (
    .aclk(aclk),
    .aresetn(aresetn),
    .scl(scl),
    .sda(sda),
    .byte_valid(byte_valid),
    .byte_data(byte_data),
    .in_frame(frame)
  );

  lcd_cmd_dec u_dec (
    .cmd_byte(byte_data),
    .cmd(cmd)
  );

  assign cmd_go = byte_valid & ~data_mode_q;
  assign data_go = byte_valid & data_mode_q;
  assign bank_ok = st_q.mode == lcd_pkg::MODE_STATIC || st_q.mode == lcd_pkg::MODE_MUX2;

  // ---------------- display data filling ----------------
  logic fill_q;
  logic [7:0] fill_byte_q;
  logic [3:0] fill_left_q;
  logic [2:0] bpa;
  logic [1:0] in_base;
  logic [6:0] ptr_next;

  // bits per RAM address follow the backplane count
  assign bpa = (st_q.mode == lcd_pkg::MODE_STATIC) ? 3'd1 :
    (st_q.mode == lcd_pkg::MODE_MUX2) ? 3'd2 :
    (st_q.mode == lcd_pkg::MODE_MUX3) ? 3'd3 : 3'd4;
  // input bank picks row 2 or rows 2 and 3
  assign in_base = (bank_ok && st_q.in_bank) ? 2'd2 : 2'd0;
  assign ptr_next = (st_q.ptr >= lcd_pkg::PTR_MAX) ? 7'h00 : st_q.ptr + 7'h01;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fill_q <= 1'b0;
      fill_byte_q <= 8'h00;
      fill_left_q <= 4'h0;
    end else if (data_go) begin
      fill_q <= 1'b1;
      fill_byte_q <= byte_data;
      fill_left_q <= 4'h8;
    end else if (fill_q) begin
      fill_byte_q <= fill_byte_q << bpa;
      fill_left_q <= (fill_left_q > {1'b0, bpa}) ? fill_left_q - {1'b0, bpa} : 4'h0;
      fill_q <= fill_left_q > {1'b0, bpa};
    end
  end

  // msb first, one address per step
  always_ff @(posedge aclk) begin
    if (fill_q && st_q.ptr < 7'd60) begin
      for (int r = 0; r < 4; r++) begin
        if (r < int'(bpa) && r < int'(fill_left_q)) begin
          ram_q[st_q.ptr[5:0]][in_base + 2'(r)] <= fill_byte_q[7 - r];
        end
      end
    end
  end

  // ---------------- display controller status ----------------
  // apply each decoded command
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '0;
    end else if (cmd_go) begin
      unique case (cmd.kind)
        lcd_pkg::CMD_MODE: begin
          st_q.disp_en <= cmd.arg[3];
          st_q.bias_half <= cmd.arg[2];
          st_q.mode <= cmd.arg[1:0];
        end
        lcd_pkg::CMD_PTR: st_q.ptr <= cmd.arg;
        lcd_pkg::CMD_DEV: st_q.subaddr <= cmd.arg[2:0];
        // only static and 1:2 switch banks
        lcd_pkg::CMD_BANK: begin
          if (bank_ok) begin
            st_q.in_bank <= cmd.arg[1];
            st_q.out_bank <= cmd.arg[0];
          end
        end
        lcd_pkg::CMD_BLINK: begin
          st_q.blink_style_bit <= cmd.arg[2];
          st_q.blink_rate_field <= cmd.arg[1:0];
        end
        lcd_pkg::CMD_NONE: st_q <= st_q;
      endcase
    end else if (fill_q) begin
      st_q.ptr <= ptr_next;
    end
  end

  // ---------------- blink timing ----------------
  logic [$clog2(FCLK_DIV)-1:0] div_q;
  logic tick_q;
  logic [10:0] blink_cnt_q;
  logic [10:0] half_max;
  logic alt_eff, swap, blank_blink;

  // half periods of 384, 768, 1536 ticks
  assign half_max = (st_q.blink_rate_field == 2'h1) ? 11'(lcd_pkg::BLINK_DIV1 / 2 - 1) :
    (st_q.blink_rate_field == 2'h2) ? 11'(lcd_pkg::BLINK_DIV2 / 2 - 1) :
    11'(lcd_pkg::BLINK_DIV3 / 2 - 1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= div_q == $bits(div_q)'(FCLK_DIV - 1);
      div_q <= (div_q == $bits(div_q)'(FCLK_DIV - 1)) ? '0 : div_q + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || st_q.blink_rate_field == 2'h0) begin
      blink_cnt_q <= 11'h000;
      phase_q <= 1'b0;
    end else if (tick_q) begin
      blink_cnt_q <= (blink_cnt_q >= half_max) ? 11'h000 : blink_cnt_q + 11'h001;
      if (blink_cnt_q >= half_max) begin
        phase_q <= ~phase_q;
      end
    end
  end

  // alternate style only where a spare bank exists
  assign alt_eff = st_q.blink_style_bit & bank_ok;
  // swap displayed rows on the blink phase
  assign swap = alt_eff & phase_q;
  assign blank_blink = ~alt_eff & phase_q;

  // ---------------- outputs ----------------
  logic [1:0] scan_q;
  logic [1:0] scan_last;
  logic [1:0] out_base;

  assign scan_last = (st_q.mode == lcd_pkg::MODE_STATIC) ? 2'd0 :
    (st_q.mode == lcd_pkg::MODE_MUX2) ? 2'd1 :
    (st_q.mode == lcd_pkg::MODE_MUX3) ? 2'd2 : 2'd3;
  // output bank picks row 2 or rows 2 and 3
  assign out_base = (bank_ok && (st_q.out_bank ^ swap)) ? 2'd2 : 2'd0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scan_q <= 2'd0;
    end else if (scan_q > scan_last) begin
      scan_q <= 2'd0;
    end else if (tick_q) begin
      scan_q <= (scan_q == scan_last) ? 2'd0 : scan_q + 2'd1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lcd_supply_level_q <= 1'b1;
      bias_half_q <= 1'b0;
      drive_mode_q <= lcd_pkg::MODE_MUX4;
      row_sel_q <= 2'd0;
    end else begin
      // blank by holding every output at the supply level
      lcd_supply_level_q <= ~st_q.disp_en | blank_blink;
      // bias has no meaning in static mode
      bias_half_q <= st_q.bias_half & (st_q.mode != lcd_pkg::MODE_STATIC);
      // drive mode passed to the waveform stage
      drive_mode_q <= st_q.mode;
      row_sel_q <= out_base + scan_q;
    end
  end

  for (genvar i = 0; i < lcd_pkg::RAM_DEPTH; i++) begin : g_seg
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        seg_q[i] <= 1'b0;
      end else begin
        seg_q[i] <= ram_q[i][out_base + scan_q];
      end
    end
  end

  // ---------------- checks ----------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_MODE_LOAD: assert property (cmd_go && cmd.kind == lcd_pkg::CMD_MODE |=>
    st_q.mode == $past(byte_data[1:0]) && st_q.disp_en == $past(byte_data[3]))
    else $error("mode-set fields not loaded");
  AST_PTR_LOAD: assert property (cmd_go && !byte_data[7] |=>
    st_q.ptr == $past(byte_data[6:0]))
    else $error("data pointer not loaded");
  AST_DEV_LOAD: assert property (cmd_go && cmd.kind == lcd_pkg::CMD_DEV |=>
    st_q.subaddr == $past(byte_data[2:0]))
    else $error("subaddress not loaded");
  AST_BANK_IGNORED: assert property (cmd_go && cmd.kind == lcd_pkg::CMD_BANK && !bank_ok
    |=> $stable(st_q.in_bank) && $stable(st_q.out_bank))
    else $error("bank changed in 1:3 or 1:4 mode");
  AST_BLINK_LOAD: assert property (cmd_go && cmd.kind == lcd_pkg::CMD_BLINK |=>
    st_q.blink_rate_field == $past(byte_data[1:0]))
    else $error("blink rate not loaded");
  AST_NONE_STABLE: assert property (cmd_go && cmd.kind == lcd_pkg::CMD_NONE |=>
    $stable(st_q))
    else $error("unknown command altered status");
  AST_BLANK: assert property (!st_q.disp_en ##1 !$past(st_q.disp_en) |->
    lcd_supply_level_q)
    else $error("disabled display not blanked");
  AST_BIAS_STATIC: assert property (st_q.mode == lcd_pkg::MODE_STATIC |=>
    !bias_half_q)
    else $error("bias active in static mode");
  AST_NO_SWAP_MUX: assert property (!bank_ok && st_q.blink_style_bit && phase_q |=>
    lcd_supply_level_q)
    else $error("1:3 or 1:4 mode did not blank the whole display");
  AST_FILL_MUX4: assert property (data_go && st_q.mode == lcd_pkg::MODE_MUX4 |=>
    fill_q ##1 fill_q ##1 !fill_q)
    else $error("1:4 fill did not take two addresses");

  COV_MODE_CMD: cover property (cmd_go && cmd.kind == lcd_pkg::CMD_MODE);
  COV_ALT_SWAP: cover property (swap && st_q.disp_en);
  COV_FILL_STATIC: cover property (data_go && st_q.mode == lcd_pkg::MODE_STATIC);
endmodule : lcd_driver_top

// >>> lcd_pkg.sv
package lcd_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_RADDR = 8'h08;
  localparam logic [7:0] ADDR_RDATA = 8'h0C;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam int RAM_DEPTH = 60;
  localparam logic [6:0] PTR_MAX = 7'h3B;
  localparam logic [3:0] OP_MODE = 4'hC;
  localparam logic [4:0] OP_DEV = 5'h1C;
  localparam logic [5:0] OP_BANK = 6'h3E;
  localparam logic [4:0] OP_BLINK = 5'h1E;
  localparam logic [1:0] MODE_STATIC = 2'h1;
  localparam logic [1:0] MODE_MUX2 = 2'h2;
  localparam logic [1:0] MODE_MUX3 = 2'h3;
  localparam logic [1:0] MODE_MUX4 = 2'h0;
  localparam int CLK_HZ = 100000000;
  localparam int FCLK_HZ = 1536;
  localparam int FCLK_DIV_DEF = CLK_HZ / FCLK_HZ;
  localparam int BLINK_DIV1 = 768;
  localparam int BLINK_DIV2 = 1536;
  localparam int BLINK_DIV3 = 3072;
  localparam int STAT_PTR_LSB = 12;
  localparam int STAT_FRAME = 19;
  localparam int STAT_PHASE = 20;

  typedef enum logic [2:0] {CMD_NONE, CMD_MODE, CMD_PTR, CMD_DEV, CMD_BANK, CMD_BLINK} lcd_cmd_e;

  typedef struct packed {
    lcd_cmd_e kind;
    logic [6:0] arg;
  } lcd_cmd_s;

  typedef struct packed {
    logic [6:0] ptr;
    logic [1:0] blink_rate_field;
    logic blink_style_bit;
    logic out_bank;
    logic in_bank;
    logic [2:0] subaddr;
    logic [1:0] mode;
    logic bias_half;
    logic disp_en;
  } lcd_status_s;
endpackage : lcd_pkg

// >>> lcd_cmd_dec.sv
`timescale 1ns/1ps
module lcd_cmd_dec (
  input wire logic [7:0] cmd_byte,
  output lcd_pkg::lcd_cmd_s cmd
);
  function automatic lcd_pkg::lcd_cmd_e classify(input logic [7:0] b);
    if (!b[7]) begin
      return lcd_pkg::CMD_PTR;
    end else if (b[7:4] == lcd_pkg::OP_MODE) begin
      return lcd_pkg::CMD_MODE;
    end else if (b[7:3] == lcd_pkg::OP_DEV) begin
      return lcd_pkg::CMD_DEV;
    end else if (b[7:2] == lcd_pkg::OP_BANK) begin
      return lcd_pkg::CMD_BANK;
    end else if (b[7:3] == lcd_pkg::OP_BLINK) begin
      return lcd_pkg::CMD_BLINK;
    end
    return lcd_pkg::CMD_NONE;
  endfunction : classify

  assign cmd.kind = classify(cmd_byte);
  assign cmd.arg = cmd_byte[6:0];
endmodule : lcd_cmd_dec

// >>> lcd_i2c_rx.sv
`timescale 1ns/1ps
module lcd_i2c_rx (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic scl,
  input wire logic sda,
  output logic byte_valid,
  output logic [7:0] byte_data,
  output logic in_frame
);
  logic scl_m_q, scl_s_q, scl_p_q;
  logic sda_m_q, sda_s_q, sda_p_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] sh_q;
  logic start_det, stop_det, scl_rise;

  assign start_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign stop_det = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
  assign scl_rise = scl_s_q & ~scl_p_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
      {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
    end else begin
      {scl_m_q, scl_s_q, scl_p_q} <= {scl, scl_m_q, scl_s_q};
      {sda_m_q, sda_s_q, sda_p_q} <= {sda, sda_m_q, sda_s_q};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_frame <= 1'b0;
      bit_cnt_q <= 4'h0;
      sh_q <= 8'h00;
      byte_valid <= 1'b0;
      byte_data <= 8'h00;
    end else begin
      byte_valid <= 1'b0;
      if (start_det) begin
        in_frame <= 1'b1;
        bit_cnt_q <= 4'h0;
      end else if (stop_det) begin
        in_frame <= 1'b0;
      // data sampled only at clock rise
      end else if (scl_rise && in_frame) begin
        if (bit_cnt_q == 4'h8) begin
          bit_cnt_q <= 4'h0;
        end else begin
          sh_q <= {sh_q[6:0], sda_s_q};
          bit_cnt_q <= bit_cnt_q + 4'h1;
        end
        if (bit_cnt_q == 4'h7) begin
          byte_valid <= 1'b1;
          byte_data <= {sh_q[6:0], sda_s_q};
        end
      end
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_START_OPENS: assert property (start_det |=> in_frame)
    else $error("start did not open a frame");
  AST_STOP_CLOSES: assert property (stop_det && !start_det |=> !in_frame)
    else $error("stop did not close the frame");
  COV_BYTE: cover property (in_frame ##1 byte_valid);
endmodule : lcd_i2c_rx

// >>> lcd_i2c_master.sv
`timescale 1ns/1ps
module lcd_i2c_master #(
  parameter int HALF = 6
) (
  input wire logic aclk,
  output logic scl,
  output logic sda
);
  // both lines pulled up when nobody drives low
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  task automatic hold();
    repeat (HALF) @(posedge aclk);
  endtask : hold

  task automatic start_cond();
    @(posedge aclk);
    sda <= 1'b0;
    hold();
    scl <= 1'b0;
    hold();
  endtask : start_cond

  // data moves only while clock low
  task automatic put_byte(input logic [7:0] b);
    for (int i = 8; i >= 0; i--) begin
      sda <= (i == 0) ? 1'b1 : b[i-1];
      hold();
      scl <= 1'b1;
      hold();
      scl <= 1'b0;
      hold();
    end
  endtask : put_byte

  task automatic stop_cond();
    sda <= 1'b0;
    hold();
    scl <= 1'b1;
    hold();
    sda <= 1'b1;
    hold();
  endtask : stop_cond
endmodule : lcd_i2c_master

// >>> lcd_driver_command_decoder_bench.sv
`timescale 1ns/1ps
module lcd_driver_command_decoder_bench;
  localparam int DIV = 4;
  localparam int LIMIT = 80000;
  logic aclk, aresetn;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, d, s0;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r, drive_mode_q, row_sel_q;
  logic scl, sda, lcd_supply_level_q, bias_half_q, row2;
  logic [59:0] seg_q;
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;

  lcd_driver_top #(.FCLK_DIV(DIV)) dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .scl(scl), .sda(sda), .lcd_supply_level_q(lcd_supply_level_q),
    .bias_half_q(bias_half_q), .drive_mode_q(drive_mode_q), .row_sel_q(row_sel_q),
    .seg_q(seg_q));

  lcd_i2c_master pm (.aclk(aclk), .scl(scl), .sda(sda));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      err_total++;
      $display("unexpected timeout expected %0d seen %0d", LIMIT - 1, cycles);
      results();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_resp

  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= v;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        bready <= 1'b0;
        chk_resp("bresp", e, bresp);
        done = 1'b1;
      end
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        rready <= 1'b0;
        v = rdata;
        rs = rresp;
        done = 1'b1;
      end
    end
  endtask : rd

  task automatic cmd(input logic [7:0] b);
    pm.start_cond();
    pm.put_byte(b);
    pm.stop_cond();
  endtask : cmd

  task automatic stat();
    rd(lcd_pkg::ADDR_STAT, d, r);
    chk_resp("stat resp", lcd_pkg::RESP_OKAY, r);
  endtask : stat

  task automatic watch(input int lim, output int hi, output logic saw2);
    hi = 0;
    saw2 = 1'b0;
    repeat (lim) begin
      @(posedge aclk);
      if (lcd_supply_level_q === 1'b1) hi++;
      if (row_sel_q === 2'h2) saw2 = 1'b1;
    end
  endtask : watch

  task automatic blink_len(input int lim, output int len);
    int k;
    k = 0;
    len = 0;
    while (lcd_supply_level_q !== 1'b1 && k < lim) begin
      @(posedge aclk);
      k++;
    end
    while (lcd_supply_level_q === 1'b1 && len < 2 * lim) begin
      @(posedge aclk);
      len++;
    end
  endtask : blink_len

  initial begin
    aresetn = 1'b0;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hF;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("blank", 32'h1, {31'h0, lcd_supply_level_q});
    chk("mode", 32'h0, {30'h0, drive_mode_q});
    stat();
    chk("stat reset", 32'h0, d);
    wr(8'h10, 32'h0, lcd_pkg::RESP_DECERR);
    rd(8'h10, d, r);
    chk_resp("unmapped", lcd_pkg::RESP_DECERR, r);
    for (int m = 0; m < 4; m++) begin
      cmd(8'hCC | 8'(m));
      stat();
      chk("stat mode", {28'h0, 2'(m), 2'h3}, {28'h0, d[3:0]});
      chk("mode out", 32'(m), {30'h0, drive_mode_q});
      chk("bias", (m == 1) ? 32'h0 : 32'h1, {31'h0, bias_half_q});
      chk("enabled", 32'h0, {31'h0, lcd_supply_level_q});
    end
    pm.start_cond();
    stat();
    chk("in frame", 32'h1, {31'h0, d[lcd_pkg::STAT_FRAME]});
    pm.put_byte(8'h3B);
    pm.stop_cond();
    stat();
    chk("frame end", 32'h0, {31'h0, d[lcd_pkg::STAT_FRAME]});
    chk("pointer", 32'd59, {25'h0, d[18:12]});
    cmd(8'hE5);
    stat();
    chk("subaddr", 32'h5, {29'h0, d[6:4]});
    s0 = d;
    cmd(8'hD5);
    cmd(8'hEA);
    cmd(8'hFF);
    stat();
    chk("unknown", s0, d);
    cmd(8'hC9);
    cmd(8'hFB);
    stat();
    chk("banks", 32'h3, {30'h0, d[8:7]});
    chk("row shown", 32'h2, {30'h0, row_sel_q});
    cmd(8'hC8);
    cmd(8'hFA);
    stat();
    chk("bank ignored", 32'h3, {30'h0, d[8:7]});
    cmd(8'hC9);
    cmd(8'hFA);
    stat();
    chk("bank in only", 32'h1, {30'h0, d[8:7]});
    chk("row back", 32'h0, {30'h0, row_sel_q});
    cmd(8'h00);
    wr(lcd_pkg::ADDR_CTRL, 32'h1, lcd_pkg::RESP_OKAY);
    cmd(8'hA5);
    wr(lcd_pkg::ADDR_CTRL, 32'h0, lcd_pkg::RESP_OKAY);
    for (int i = 0; i < 8; i++) begin
      wr(lcd_pkg::ADDR_RADDR, 32'(i), lcd_pkg::RESP_OKAY);
      rd(lcd_pkg::ADDR_RDATA, d, r);
      chk("fill row2", 32'(8'hA5 >> (7 - i)) & 32'h1, {31'h0, d[2]});
    end
    stat();
    chk("pointer after", 32'd8, {25'h0, d[18:12]});
    cmd(8'hFB);
    chk("segments", 32'hA5, {24'h0, seg_q[7:0]});
    cmd(8'hC8);
    cmd(8'h0A);
    wr(lcd_pkg::ADDR_CTRL, 32'h1, lcd_pkg::RESP_OKAY);
    cmd(8'h5C);
    wr(lcd_pkg::ADDR_CTRL, 32'h0, lcd_pkg::RESP_OKAY);
    for (int i = 0; i < 2; i++) begin
      wr(lcd_pkg::ADDR_RADDR, 32'(10 + i), lcd_pkg::RESP_OKAY);
      rd(lcd_pkg::ADDR_RDATA, d, r);
      chk("fill mux4", (i == 0) ? 32'hA : 32'h3, {28'h0, d[3:0]});
    end
    stat();
    chk("pointer mux4", 32'd12, {25'h0, d[18:12]});
    for (int k = 1; k < 4; k++) begin
      cmd(8'hF0 | 8'(k));
      stat();
      chk("blink field", 32'(k), {30'h0, d[11:10]});
      blink_len(3 * 384 * DIV << k, n);
      chk("blink half", 32'(384 * DIV << (k - 1)), 32'(n));
    end
    cmd(8'hC8);
    cmd(8'hF5);
    stat();
    chk("style", 32'h1, {31'h0, d[9]});
    watch(2 * 384 * DIV + 64, n, row2);
    chk("mux4 blanks", 32'h1, {31'(0), n > 0});
    cmd(8'hC9);
    cmd(8'hF8);
    watch(2 * 384 * DIV + 64, n, row2);
    chk("alt no blank", 32'h0, 32'(n));
    chk("alt swap", 32'h1, {31'h0, row2});
    results();
  end
endmodule : lcd_driver_command_decoder_bench
